// [tmr2_pkg.sv]
// Constants, register map and types for the timer two block
package tmr2_pkg;
  localparam logic [11:0] ADDR_CONTROL  = 12'h0c8;
  localparam logic [11:0] ADDR_MODE     = 12'h0c9;
  localparam logic [11:0] ADDR_CNT_LOW  = 12'h0cc;
  localparam logic [11:0] ADDR_CNT_HIGH = 12'h0cd;
  localparam logic [11:0] ADDR_RLD_LOW  = 12'h0ca;
  localparam logic [11:0] ADDR_RLD_HIGH = 12'h0cb;
  localparam int ADDR_W = 12;

  localparam int BIT_OVF     = 7;
  localparam int BIT_EXT     = 6;
  localparam int BIT_RXBAUD  = 5;
  localparam int BIT_TXBAUD  = 4;
  localparam int BIT_TRIGEN  = 3;
  localparam int BIT_RUN     = 2;
  localparam int BIT_SRC     = 1;
  localparam int BIT_CAPSEL  = 0;
  localparam int BIT_CLKOUT  = 1;
  localparam int BIT_UPDOWN  = 0;

  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [1:0]  MODE_RESET    = 2'h0;
  localparam logic [15:0] COUNT_TOP     = 16'hffff;
  localparam logic [15:0] COUNT_ONE     = 16'h0001;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

  // Internal tick every 12 system clocks in plain timer operation
  localparam int TICK_DIV    = 12;
  localparam int CLKOUT_DIV  = 2;

  typedef enum logic [1:0] {
    TMR2_CAPTURE  = 2'b00,
    TMR2_RELOAD   = 2'b01,
    TMR2_UPDOWN   = 2'b11,
    TMR2_CLOCKOUT = 2'b10
  } tmr2_mode_t;
endpackage : tmr2_pkg

// [tmr2_timer.sv]
// Timer two: 16-bit capture/reload/up-down counter with clock-out, APB slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module tmr2_timer
  import tmr2_pkg::*;
#(
  parameter int TICK_DIVIDER = TICK_DIV
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              count_pin_in,
  output logic                   count_pin_out,
  output logic                   count_pin_oe,
  input  wire logic              ext_trigger_pin,
  input  wire logic              timer1_overflow,
  output logic                   rx_baud_tick,
  output logic                   tx_baud_tick,
  output logic                   timer_irq
);
  // Divider is an 8-bit counter; a divide by one would hide pin edges
  if (TICK_DIVIDER < 2 || TICK_DIVIDER > 255) begin : g_bad_divider
    $error("TICK_DIVIDER out of range");
  end

  logic [7:0]  control_reg;
  logic [1:0]  mode_reg;
  logic [7:0]  count_low_reg;
  logic [7:0]  count_high_reg;
  logic [7:0]  reload_low_reg;
  logic [7:0]  reload_high_reg;
  logic [7:0]  div_reg;
  logic        cnt_s1_reg;
  logic        cnt_s2_reg;
  logic        cnt_s3_reg;
  logic        trg_s1_reg;
  logic        trg_s2_reg;
  logic        trg_s3_reg;
  logic        clkout_reg;
  logic        half_reg;
  logic        wrap_reg;
  logic [15:0] count_next;
  logic [15:0] count;
  logic [15:0] reload;
  logic        tick;
  logic        wrap;
  logic        count_up;
  logic        baud_mode;
  logic        trig_event;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        wr_control;
  logic        wr_mode;
  logic        wr_cnt_low;
  logic        wr_cnt_high;
  logic        wr_rld_low;
  logic        wr_rld_high;
  tmr2_mode_t  mode;

  assign count  = {count_high_reg, count_low_reg};
  assign reload = {reload_high_reg, reload_low_reg};
  assign baud_mode = control_reg[BIT_RXBAUD] | control_reg[BIT_TXBAUD];

  function automatic logic is_reg(input logic [ADDR_W-1:0] a);
    is_reg = (a == ADDR_CONTROL) || (a == ADDR_MODE) ||
             (a == ADDR_CNT_LOW) || (a == ADDR_CNT_HIGH) ||
             (a == ADDR_RLD_LOW) || (a == ADDR_RLD_HIGH);
  endfunction : is_reg

  // APB: zero wait states, unmapped addresses answer with pslverr
  assign addr_ok = is_reg(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign wr_control  = wr_en & (paddr == ADDR_CONTROL);
  assign wr_mode     = wr_en & (paddr == ADDR_MODE);
  assign wr_cnt_low  = wr_en & (paddr == ADDR_CNT_LOW);
  assign wr_cnt_high = wr_en & (paddr == ADDR_CNT_HIGH);
  assign wr_rld_low  = wr_en & (paddr == ADDR_RLD_LOW);
  assign wr_rld_high = wr_en & (paddr == ADDR_RLD_HIGH);

  always_comb begin
    if (mode_reg[BIT_CLKOUT]) begin
      mode = TMR2_CLOCKOUT;
    end else if (baud_mode || !control_reg[BIT_CAPSEL]) begin
      mode = mode_reg[BIT_UPDOWN] && !baud_mode ? TMR2_UPDOWN
                                                : TMR2_RELOAD;
    end else begin
      mode = TMR2_CAPTURE;
    end
  end

  // Pin synchronisers; edge detect reads only settled samples
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_s1_reg <= 1'b1;
      cnt_s2_reg <= 1'b1;
      cnt_s3_reg <= 1'b1;
      trg_s1_reg <= 1'b1;
      trg_s2_reg <= 1'b1;
      trg_s3_reg <= 1'b1;
    end else begin
      cnt_s1_reg <= count_pin_in;
      cnt_s2_reg <= cnt_s1_reg;
      cnt_s3_reg <= cnt_s2_reg;
      trg_s1_reg <= ext_trigger_pin;
      trg_s2_reg <= trg_s1_reg;
      trg_s3_reg <= trg_s2_reg;
    end
  end

  // Trigger falls only act outside up/down and outside baud use
  assign trig_event = trg_s3_reg & ~trg_s2_reg & control_reg[BIT_TRIGEN] &
                      ~baud_mode & (mode != TMR2_UPDOWN);
  assign count_up = (mode != TMR2_UPDOWN) | trg_s2_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      div_reg  <= BYTE_ZERO;
      half_reg <= 1'b0;
    end else begin
      if (div_reg == 8'(TICK_DIVIDER - 1)) begin
        div_reg <= BYTE_ZERO;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
      half_reg <= ~half_reg;
    end
  end

  always_comb begin
    if (!control_reg[BIT_RUN]) begin
      tick = 1'b0;
    end else if (mode == TMR2_CLOCKOUT) begin
      tick = half_reg;
    end else if (control_reg[BIT_SRC]) begin
      tick = cnt_s3_reg & ~cnt_s2_reg;
    end else begin
      tick = (div_reg == BYTE_ZERO);
    end
  end

  always_comb begin
    count_next = count;
    wrap       = 1'b0;
    if (tick) begin
      if (count_up) begin
        if (count == COUNT_TOP) begin
          wrap = 1'b1;
          count_next = (mode == TMR2_CAPTURE) ? {BYTE_ZERO, BYTE_ZERO}
                                              : reload;
        end else begin
          count_next = count + COUNT_ONE;
        end
      end else if (count == reload) begin
        wrap = 1'b1;
        count_next = COUNT_TOP;
      end else begin
        count_next = count - COUNT_ONE;
      end
    end
    if (trig_event && mode == TMR2_RELOAD) begin
      count_next = reload;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_low_reg  <= BYTE_ZERO;
      count_high_reg <= BYTE_ZERO;
    end else if (wr_cnt_low) begin
      count_low_reg <= pwdata[7:0];
    end else if (wr_cnt_high) begin
      count_high_reg <= pwdata[7:0];
    end else begin
      count_low_reg  <= count_next[7:0];
      count_high_reg <= count_next[15:8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reload_low_reg  <= BYTE_ZERO;
      reload_high_reg <= BYTE_ZERO;
    end else if (trig_event && mode == TMR2_CAPTURE) begin
      reload_low_reg  <= count_low_reg;
      reload_high_reg <= count_high_reg;
    end else if (wr_rld_low) begin
      reload_low_reg <= pwdata[7:0];
    end else if (wr_rld_high) begin
      reload_high_reg <= pwdata[7:0];
    end
  end

  // Flags: hardware set wins over a same-cycle software clear
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      control_reg <= CONTROL_RESET;
    end else begin
      if (wr_control) begin
        control_reg <= pwdata[7:0];
      end
      if (wrap && !baud_mode && mode != TMR2_CLOCKOUT) begin
        control_reg[BIT_OVF] <= 1'b1;
      end
      if (trig_event) begin
        control_reg[BIT_EXT] <= 1'b1;
      end else if (wrap && mode == TMR2_UPDOWN) begin
        control_reg[BIT_EXT] <= ~control_reg[BIT_EXT];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_reg <= MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clkout_reg <= 1'b0;
      wrap_reg   <= 1'b0;
    end else begin
      wrap_reg <= wrap;
      if (wrap && mode == TMR2_CLOCKOUT) begin
        clkout_reg <= ~clkout_reg;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata <= DATA_ZERO;
    end else if (rd_en) begin
      case (paddr)
        ADDR_CONTROL:  prdata <= {24'h000000, control_reg};
        ADDR_MODE:     prdata <= {30'h0, mode_reg};
        ADDR_CNT_LOW:  prdata <= {24'h000000, count_low_reg};
        ADDR_CNT_HIGH: prdata <= {24'h000000, count_high_reg};
        ADDR_RLD_LOW:  prdata <= {24'h000000, reload_low_reg};
        ADDR_RLD_HIGH: prdata <= {24'h000000, reload_high_reg};
        default:       prdata <= DATA_ZERO;
      endcase
    end
  end

  assign count_pin_out = clkout_reg;
  assign count_pin_oe  = mode_reg[BIT_CLKOUT];
  // Serial clocks: overflow of this timer feeds the port when selected
  assign rx_baud_tick = control_reg[BIT_RXBAUD] ? wrap_reg
                                                : timer1_overflow;
  assign tx_baud_tick = control_reg[BIT_TXBAUD] ? wrap_reg
                                                : timer1_overflow;
  // External flag raises no interrupt in up/down mode
  assign timer_irq = control_reg[BIT_OVF] |
                     (control_reg[BIT_EXT] & ~mode_reg[BIT_UPDOWN]);

  // Counting, capture, flags, interrupt and baud ticks
  a_ovf_sets: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    wrap && !baud_mode && mode != TMR2_CLOCKOUT |=> control_reg[BIT_OVF])
    else $error("overflow flag not set");
  a_ovf_baud: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    baud_mode && !wr_control && !control_reg[BIT_OVF]
    |=> !control_reg[BIT_OVF])
    else $error("overflow flag set in baud mode");
  a_ovf_sticky: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    control_reg[BIT_OVF] && !wr_control |=> control_reg[BIT_OVF])
    else $error("overflow flag dropped by itself");
  a_irq_ovf: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    control_reg[BIT_OVF] |-> timer_irq)
    else $error("overflow flag without interrupt");
  a_up_reload: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    tick && count_up && count == COUNT_TOP && mode != TMR2_CAPTURE && !wr_en
    |=> count == $past(reload))
    else $error("reload on overflow missing");
  a_down_top: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    tick && !count_up && count == reload && !wr_en |=> count == COUNT_TOP)
    else $error("underflow load wrong");
  a_count_inc: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    tick && count_up && count != COUNT_TOP && !wr_cnt_low && !wr_cnt_high
    && !(trig_event && mode == TMR2_RELOAD)
    |=> count == $past(count) + COUNT_ONE)
    else $error("count did not step up");
  a_count_dec: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    tick && !count_up && count != reload && !wr_cnt_low && !wr_cnt_high
    |=> count == $past(count) - COUNT_ONE)
    else $error("count did not step down");
  a_capture_roll: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    tick && count_up && count == COUNT_TOP && mode == TMR2_CAPTURE
    && !wr_cnt_low && !wr_cnt_high |=> count == {BYTE_ZERO, BYTE_ZERO})
    else $error("capture mode overflow reloaded");
  a_trig_reload: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    trig_event && mode == TMR2_RELOAD && !wr_cnt_low && !wr_cnt_high
    |=> count == $past(reload))
    else $error("trigger reload missing");
  a_stopped: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    !control_reg[BIT_RUN] && !wr_en && !trig_event |=> $stable(count))
    else $error("count moved while stopped");
  a_src_ext: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    control_reg[BIT_RUN] && control_reg[BIT_SRC] && mode != TMR2_CLOCKOUT
    && !(cnt_s3_reg && !cnt_s2_reg) && !wr_cnt_low && !wr_cnt_high
    && !trig_event |=> $stable(count))
    else $error("counter moved without pin fall");
  a_capture_copy: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    trig_event && mode == TMR2_CAPTURE |=> reload == $past(count))
    else $error("capture failed");
  a_ext_set: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    trig_event |=> control_reg[BIT_EXT])
    else $error("external flag not set");
  a_ext_sticky: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    control_reg[BIT_EXT] && !wr_control && !(wrap && mode == TMR2_UPDOWN)
    |=> control_reg[BIT_EXT])
    else $error("external flag dropped by itself");
  a_trig_off: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    !control_reg[BIT_TRIGEN] && mode != TMR2_UPDOWN && !wr_control
    && !control_reg[BIT_EXT] |=> !control_reg[BIT_EXT])
    else $error("trigger acted while disabled");
  a_baud_no_ext: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    baud_mode && !wr_control && !control_reg[BIT_EXT]
    |=> !control_reg[BIT_EXT])
    else $error("trigger acted in baud mode");
  a_ext_toggle: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    wrap && mode == TMR2_UPDOWN && !wr_en
    |=> control_reg[BIT_EXT] != $past(control_reg[BIT_EXT]))
    else $error("external flag not toggled");
  a_irq_updown: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    mode_reg[BIT_UPDOWN] && !control_reg[BIT_OVF] |-> !timer_irq)
    else $error("interrupt from external flag in up/down mode");
  a_rx_source: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    control_reg[BIT_RXBAUD] && wrap && !wr_control |=> rx_baud_tick)
    else $error("receive tick missing on overflow");
  a_tx_source: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    control_reg[BIT_TXBAUD] && wrap && !wr_control |=> tx_baud_tick)
    else $error("transmit tick missing on overflow");
  // Clock-out and reset
  a_clkout_half: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    control_reg[BIT_RUN] && mode == TMR2_CLOCKOUT && tick
    |=> !tick || mode != TMR2_CLOCKOUT)
    else $error("clock-out ticks faster than half rate");
  a_ovf_clkout: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    mode == TMR2_CLOCKOUT && !wr_control && !control_reg[BIT_OVF]
    |=> !control_reg[BIT_OVF])
    else $error("overflow flag set in clock-out mode");
  a_clkout_toggle: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    wrap && mode == TMR2_CLOCKOUT |=> count_pin_out != $past(count_pin_out))
    else $error("clock out did not toggle");
  a_clkout_quiet: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    mode != TMR2_CLOCKOUT |=> $stable(count_pin_out))
    else $error("clock out moved outside clock-out mode");
  a_reset_ctrl: assert property (@(posedge clk_sys)
    !reset_n |=> control_reg == CONTROL_RESET)
    else $error("control register not cleared by reset");
  a_reset_mode: assert property (@(posedge clk_sys)
    !reset_n |=> mode_reg == MODE_RESET)
    else $error("mode register not cleared by reset");
endmodule : tmr2_timer

// [tmr2_pin_model.sv]
// Pin-side model: external count pin and trigger pin of timer two
`timescale 1ns/100ps
module tmr2_pin_model (
  input  wire logic clk_sys,
  input  wire logic count_pin_oe,
  input  wire logic count_pin_out,
  output logic      count_pin_in,
  output logic      ext_trigger_pin
);
  logic drive;
  initial begin
    drive = 1'b1;
    ext_trigger_pin = 1'b1;
  end
  // Pulled high when idle; the block's wave wins while it drives
  assign count_pin_in = count_pin_oe ? count_pin_out : drive;
  // Each level held 3 clocks so the three-flop sampler sees every fall
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      drive <= 1'b0;
      repeat (3) @(posedge clk_sys);
      drive <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask : edges
  task automatic trig(input logic lvl);
    @(posedge clk_sys);
    ext_trigger_pin <= lvl;
    repeat (5) @(posedge clk_sys);
  endtask : trig
endmodule : tmr2_pin_model

// [timer2_updown_clockout_test.sv]
// Self-checking testbench of the timer two block
`timescale 1ns/100ps
module timer2_updown_clockout_test
  import tmr2_pkg::*;
;
  logic              clk_sys;
  logic              reset_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              count_pin_in;
  logic              count_pin_out;
  logic              count_pin_oe;
  logic              ext_trigger_pin;
  logic              timer1_overflow;
  logic              rx_baud_tick;
  logic              tx_baud_tick;
  logic              timer_irq;
  logic [31:0]       rd;
  logic              err;
  int                mismatches;
  int                n_compared;
  int                cycles;
  int                n;

  // Short tick divider keeps the run brief
  tmr2_timer #(.TICK_DIVIDER(2)) uut (
    .clk_sys         (clk_sys),
    .reset_n         (reset_n),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .count_pin_in    (count_pin_in),
    .count_pin_out   (count_pin_out),
    .count_pin_oe    (count_pin_oe),
    .ext_trigger_pin (ext_trigger_pin),
    .timer1_overflow (timer1_overflow),
    .rx_baud_tick    (rx_baud_tick),
    .tx_baud_tick    (tx_baud_tick),
    .timer_irq       (timer_irq)
  );
  tmr2_pin_model pins (
    .clk_sys(clk_sys), .count_pin_oe(count_pin_oe),
    .count_pin_out(count_pin_out), .count_pin_in(count_pin_in),
    .ext_trigger_pin(ext_trigger_pin)
  );

  task automatic finish_test;
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd8(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd[15:0], {8'h00, exp});
  endtask : rd8
  task automatic w16(input logic [11:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 12'h001, v[15:8]);
  endtask : w16
  task automatic r16(input logic [11:0] a, input logic [15:0] exp);
    logic [7:0] lo;
    apb(1'b0, a, 8'h00);
    lo = rd[7:0];
    apb(1'b0, a + 12'h001, 8'h00);
    chk({rd[7:0], lo}, exp);
  endtask : r16
  task automatic run_len(input logic lvl);
    n = 0;
    while (count_pin_out === lvl && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : run_len

  task automatic t_reset;
    rd8(ADDR_CONTROL, 8'h00);
    rd8(ADDR_MODE, 8'h00);
    chk(count_pin_oe, 1'b0);
    apb(1'b0, 12'h0d0, 8'h00);
    chk({rd[15:0]}, 16'h0000);
    chk(err, 1'b1);
  endtask : t_reset
  task automatic t_extcount;
    w16(ADDR_CNT_LOW, 16'h00ff);
    wr(ADDR_CONTROL, 8'h02);
    pins.edges(3);
    r16(ADDR_CNT_LOW, 16'h00ff);
    wr(ADDR_CONTROL, 8'h06);
    pins.edges(2);
    wr(ADDR_CONTROL, 8'h02);
    r16(ADDR_CNT_LOW, 16'h0101);
  endtask : t_extcount
  task automatic t_overflow;
    w16(ADDR_RLD_LOW, 16'h1234);
    w16(ADDR_CNT_LOW, 16'hfffe);
    wr(ADDR_CONTROL, 8'h04);
    repeat (100) if (timer_irq !== 1'b1) @(negedge clk_sys);
    wr(ADDR_CONTROL, 8'h80);
    rd8(ADDR_CONTROL, 8'h80);
    rd8(ADDR_CNT_HIGH, 8'h12);
    chk(timer_irq, 1'b1);
    wr(ADDR_CONTROL, 8'h00);
    @(negedge clk_sys);
    chk(timer_irq, 1'b0);
  endtask : t_overflow
  task automatic t_capture;
    w16(ADDR_CNT_LOW, 16'h0000);
    wr(ADDR_CONTROL, 8'h07);
    pins.trig(1'b0);
    pins.trig(1'b1);
    rd8(ADDR_CONTROL, 8'h07);
    wr(ADDR_CONTROL, 8'h0f);
    pins.edges(7);
    pins.trig(1'b0);
    rd8(ADDR_RLD_LOW, 8'h07);
    rd8(ADDR_CONTROL, 8'h4f);
    chk(timer_irq, 1'b1);
    pins.trig(1'b1);
    wr(ADDR_CONTROL, 8'h00);
  endtask : t_capture
  task automatic t_updown;
    wr(ADDR_MODE, 8'h01);
    w16(ADDR_RLD_LOW, 16'h0010);
    w16(ADDR_CNT_LOW, 16'h0010);
    pins.trig(1'b0);
    wr(ADDR_CONTROL, 8'h06);
    pins.edges(1);
    rd8(ADDR_CONTROL, 8'hc6);
    wr(ADDR_CONTROL, 8'h42);
    r16(ADDR_CNT_LOW, 16'hffff);
    chk(timer_irq, 1'b0);
    pins.trig(1'b1);
    wr(ADDR_CONTROL, 8'h46);
    pins.edges(1);
    rd8(ADDR_CONTROL, 8'h86);
    wr(ADDR_CONTROL, 8'h02);
    r16(ADDR_CNT_LOW, 16'h0010);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, 8'h00);
  endtask : t_updown
  task automatic t_baud;
    wr(ADDR_CONTROL, 8'h20);
    @(posedge clk_sys);
    timer1_overflow <= 1'b1;
    @(negedge clk_sys);
    chk(tx_baud_tick, 1'b1);
    chk(rx_baud_tick, 1'b0);
    @(posedge clk_sys);
    timer1_overflow <= 1'b0;
    w16(ADDR_RLD_LOW, 16'hfffe);
    w16(ADDR_CNT_LOW, 16'hfffe);
    wr(ADDR_CONTROL, 8'h25);
    repeat (100) if (rx_baud_tick !== 1'b1) @(negedge clk_sys);
    chk(rx_baud_tick, 1'b1);
    rd8(ADDR_CONTROL, 8'h25);
    rd8(ADDR_CNT_HIGH, 8'hff);
    wr(ADDR_CONTROL, 8'h00);
  endtask : t_baud
  task automatic t_clkout;
    wr(ADDR_MODE, 8'h02);
    w16(ADDR_RLD_LOW, 16'hfffe);
    w16(ADDR_CNT_LOW, 16'hfffe);
    wr(ADDR_CONTROL, 8'h14);
    chk(count_pin_oe, 1'b1);
    repeat (100) if (count_pin_out !== 1'b1) @(negedge clk_sys);
    run_len(1'b1);
    run_len(1'b0);
    chk(n[15:0], 16'h0004);
    run_len(1'b1);
    chk(n[15:0], 16'h0004);
    repeat (100) if (tx_baud_tick !== 1'b1) @(negedge clk_sys);
    chk(tx_baud_tick, 1'b1);
    rd8(ADDR_CONTROL, 8'h14);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, 8'h00);
  endtask : t_clkout

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    timer1_overflow = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_extcount();
    t_overflow();
    t_capture();
    t_updown();
    t_baud();
    t_clkout();
    finish_test();
  end
endmodule : timer2_updown_clockout_test
